// ### include/esf_consts.vh
// constants for the ecg sample fifo readout block
`ifndef ESF_CONSTS_VH
`define ESF_CONSTS_VH
// register addresses (7-bit serial address space)
`define ESF_ADDR_ECG_SAMPLE_BURST_READ 7'h20
`define ESF_ADDR_ECG_SINGLE 7'h21
`define ESF_ADDR_IMP_BURST 7'h22
`define ESF_ADDR_IMP_SINGLE 7'h23
`define ESF_ADDR_BEAT 7'h25
// fifo geometry
`define ESF_DEPTH 32
`define ESF_WIDTH 24
// sclk edge counts and burst word limit
`define ESF_FIRST_WORD_EDGE 6'd32
`define ESF_WORD_EDGES 5'd24
`define ESF_BURST_MAX 5'd31
// word field positions
`define ESF_VOLT_MSB 23
`define ESF_VOLT_LSB 6
`define ESF_TAG_MSB 5
`define ESF_TAG_LSB 3
`define ESF_PACE_MSB 2
`define ESF_PACE_LSB 0
// sample tag codes
`define ESF_TAG_VALID 3'h0
`define ESF_TAG_FAST 3'h1
`define ESF_TAG_VALID_EOF 3'h2
`define ESF_TAG_FAST_EOF 3'h3
`define ESF_TAG_EMPTY 3'h6
`define ESF_TAG_OVF 3'h7
// pace tag meaning no pace event
`define ESF_PACE_NONE 3'h7
// reset values
`define ESF_THRESH_RESET 5'h0F
`endif

// ### verilog/esf_sync.v
// two-flop synchroniser for the serial pins
`timescale 1ns/1ps
module esf_sync #(
	parameter W = 3
) (
	// clock and reset
	input wire clk_i,
	input wire reset_i,
	// async in, synced out
	input wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;
	// first stage read only by second stage
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end
	assign q_o = sync_q;
endmodule // esf_sync

// ### verilog/esf_fifo.v
// ecg sample fifo with serial readout port
`timescale 1ns/1ps
`include "esf_consts.vh"
module esf_fifo #(
	parameter DEPTH = `ESF_DEPTH,
	parameter AW = 5
) (
	// clock and reset
	input wire clk_i,
	input wire reset_i,
	// serial host port (async pins)
	input wire sclk_i,
	input wire csb_n_i,
	input wire sdi_i,
	output reg sdo_o,
	output reg sdo_oe_o,
	// sample producer, same clock
	input wire wr_i,
	input wire [17:0] wr_volt_i,
	input wire wr_fast_i,
	input wire [2:0] wr_pace_i,
	// neighbouring read locations, same clock
	input wire [19:0] imp_volt_i,
	input wire [2:0] imp_tag_i,
	input wire beat_wr_i,
	input wire [13:0] beat_interval_i,
	// control from device manager
	input wire [4:0] sample_ready_threshold_i,
	input wire resynchronise_command_i,
	input wire buffer_reset_i,
	// status
	output reg sample_ready_flag_o,
	output reg sample_overflow_flag_o,
	output reg [AW:0] unread_count_o
);
	localparam ST_ADDR = 2'd0;
	localparam ST_DATA = 2'd1;
	localparam ST_IDLE = 2'd2;

	// --------------------------------------------------
	// pin synchronisation
	// --------------------------------------------------
	wire [2:0] pin_s;
	esf_sync #(.W(3)) u_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.d_i({sclk_i, csb_n_i, sdi_i}),
		.q_o(pin_s)
	);
	wire sclk_s = pin_s[2];
	wire cs_n_s = pin_s[1];
	wire sdi_s = pin_s[0];
	reg sclk_prev_q;
	wire sclk_rise = sclk_s & ~sclk_prev_q;
	wire sclk_fall = ~sclk_s & sclk_prev_q;

	// --------------------------------------------------
	// storage
	// --------------------------------------------------
	reg [17:0] mem_volt [0:DEPTH-1];
	reg mem_fast [0:DEPTH-1];
	reg [2:0] mem_pace [0:DEPTH-1];
	reg [AW-1:0] wptr_q;
	reg [AW-1:0] rptr_q;
	reg [AW:0] count_q;
	reg ovf_q;
	reg [23:0] beat_q;
	wire clear = resynchronise_command_i | buffer_reset_i;

	// --------------------------------------------------
	// serial frame state
	// --------------------------------------------------
	reg [1:0] st_q;
	reg [5:0] bitcnt_q;
	reg [6:0] addr_q;
	reg [4:0] burst_q;
	reg [23:0] shift_q;
	reg word_pop_q;
	reg is_burst_q;

	// build a read word for an address from current state
	function [23:0] read_word;
		input [6:0] a;
		input [AW:0] cnt;
		input ovf;
		input [AW-1:0] rp;
		reg [2:0] tag;
		begin
			tag = `ESF_TAG_VALID;
			if (ovf)
				tag = `ESF_TAG_OVF;
			else if (cnt == 0)
				tag = `ESF_TAG_EMPTY;
			else if (cnt == 1)
				tag = mem_fast[rp] ? `ESF_TAG_FAST_EOF : `ESF_TAG_VALID_EOF;
			else
				tag = mem_fast[rp] ? `ESF_TAG_FAST : `ESF_TAG_VALID;
			if (a == `ESF_ADDR_ECG_SAMPLE_BURST_READ || a == `ESF_ADDR_ECG_SINGLE)
				read_word = {mem_volt[rp], tag, mem_pace[rp]};
			else if (a == `ESF_ADDR_IMP_BURST || a == `ESF_ADDR_IMP_SINGLE)
				read_word = {imp_volt_i, 1'b0, imp_tag_i};
			else if (a == `ESF_ADDR_BEAT)
				read_word = beat_q;
			else
				read_word = 24'h000000;
		end
	endfunction

	// next word as a net, so its top bit can be taken without cutting a shifted word
	wire [23:0] next_word = read_word(addr_q, count_q, ovf_q, rptr_q);
	wire is_ecg = (addr_q == `ESF_ADDR_ECG_SAMPLE_BURST_READ) || (addr_q == `ESF_ADDR_ECG_SINGLE);
	// pointer advances only on valid, non-overflowed entries, so empty reads never move it
	wire pop = sclk_rise && st_q == ST_DATA && is_ecg && (bitcnt_q == 6'd23) && !ovf_q && count_q != 0;
	wire push = wr_i && !clear;

	// --------------------------------------------------
	// serial engine: 8-bit command then 24-bit words
	// --------------------------------------------------
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sclk_prev_q <= 1'b0;
			st_q <= ST_ADDR;
			bitcnt_q <= 6'h00;
			addr_q <= 7'h00;
			burst_q <= 5'h00;
			shift_q <= 24'h000000;
			word_pop_q <= 1'b0;
			is_burst_q <= 1'b0;
			sdo_o <= 1'b0;
			sdo_oe_o <= 1'b0;
		end else begin
			sclk_prev_q <= sclk_s;
			if (cs_n_s) begin
				st_q <= ST_ADDR;
				bitcnt_q <= 6'h00;
				burst_q <= 5'h00;
				sdo_oe_o <= 1'b0;
			end else if (sclk_rise) begin
				case (st_q)
					ST_ADDR: begin
						if (bitcnt_q == 6'd7) begin
							// last command bit is read/write; writes ignored entirely
							bitcnt_q <= 6'h00;
							if (sdi_s) begin
								st_q <= ST_DATA;
								is_burst_q <= (addr_q == `ESF_ADDR_ECG_SAMPLE_BURST_READ) || (addr_q == `ESF_ADDR_IMP_BURST);
								shift_q <= read_word(addr_q, count_q, ovf_q, rptr_q);
							end else begin
								st_q <= ST_IDLE;
							end
						end else begin
							addr_q <= {addr_q[5:0], sdi_s};
							bitcnt_q <= bitcnt_q + 6'd1;
						end
					end
					ST_DATA: begin
						if (bitcnt_q == 6'd23) begin
							bitcnt_q <= 6'h00;
							// burst continues for up to 32 words, edge 32 + n*24
							if (is_burst_q && burst_q != `ESF_BURST_MAX) begin
								burst_q <= burst_q + 5'd1;
								word_pop_q <= 1'b1;
							end else begin
								st_q <= ST_IDLE;
							end
						end else begin
							bitcnt_q <= bitcnt_q + 6'd1;
							shift_q <= {shift_q[22:0], 1'b0};
						end
					end
					default: begin
						st_q <= ST_IDLE;
					end
				endcase
			end else if (sclk_fall) begin
				sdo_oe_o <= (st_q == ST_DATA);
				if (word_pop_q) begin
					// reload after the pointer moved, so a passed sample never reappears
					word_pop_q <= 1'b0;
					shift_q <= next_word;
					sdo_o <= next_word[23];
				end else begin
					sdo_o <= shift_q[23];
				end
			end
		end
	end

	// --------------------------------------------------
	// pointers, count, overflow, flags
	// --------------------------------------------------
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			wptr_q <= {AW{1'b0}};
			rptr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
			ovf_q <= 1'b0;
			beat_q <= 24'h000000;
			sample_ready_flag_o <= 1'b0;
			sample_overflow_flag_o <= 1'b0;
			unread_count_o <= {(AW+1){1'b0}};
		end else begin
			if (beat_wr_i)
				beat_q <= {beat_interval_i, 10'h000};
			if (clear) begin
				wptr_q <= {AW{1'b0}};
				rptr_q <= {AW{1'b0}};
				count_q <= {(AW+1){1'b0}};
				ovf_q <= 1'b0;
			end else begin
				if (push) begin
					wptr_q <= wptr_q + 1'b1;
					if (count_q == DEPTH)
						ovf_q <= 1'b1;
				end
				if (pop)
					rptr_q <= rptr_q + 1'b1;
				if (push && !pop && count_q != DEPTH)
					count_q <= count_q + 1'b1;
				else if (pop && !push)
					count_q <= count_q - 1'b1;
			end
			sample_overflow_flag_o <= ovf_q && !clear;
			// threshold code n means n+1 entries
			sample_ready_flag_o <= !clear && (count_q >= {1'b0, sample_ready_threshold_i} + 6'd1);
			unread_count_o <= clear ? {(AW+1){1'b0}} : count_q;
		end
	end

	// sample write port; only the producer writes memory
	always @(posedge clk_i) begin
		if (push) begin
			mem_volt[wptr_q] <= wr_volt_i;
			mem_fast[wptr_q] <= wr_fast_i;
			mem_pace[wptr_q] <= wr_pace_i;
		end
	end
endmodule // esf_fifo

// ### test/esf_fifo_chk.sv
// assertion checker for the ecg sample fifo readout
`timescale 1ns/1ps
module esf_fifo_chk #(
	parameter AW = 5
) (
	// clock and reset
	input wire clk_i,
	input wire reset_i,
	// watched inputs
	input wire csb_n_i,
	input wire wr_i,
	input wire [4:0] sample_ready_threshold_i,
	input wire resynchronise_command_i,
	input wire buffer_reset_i,
	// watched outputs
	input wire sdo_oe_o,
	input wire sample_ready_flag_o,
	input wire sample_overflow_flag_o,
	input wire [AW:0] unread_count_o
);
	// either command empties; status lags state by a cycle, hence the ##2
	wire clr = resynchronise_command_i | buffer_reset_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_count_bound: assert property (unread_count_o <= 6'd32)
		else $error("unread count above depth");
	a_flag_thresh: assert property ($stable(sample_ready_threshold_i) |->
		sample_ready_flag_o == (unread_count_o > sample_ready_threshold_i)) else $error("ready flag wrong");
	a_clear_empties: assert property (clr |-> ##2 unread_count_o == 0)
		else $error("clear left entries");
	a_clear_flag: assert property (clr |-> ##2 !sample_ready_flag_o)
		else $error("ready flag kept after clear");
	a_ovf_full: assert property ($rose(sample_overflow_flag_o) |-> unread_count_o == 6'd32)
		else $error("overflow without full buffer");
	a_ovf_holds: assert property (sample_overflow_flag_o && !clr && !$past(clr) |=> sample_overflow_flag_o)
		else $error("overflow dropped without clear");
	a_no_unread: assert property (!wr_i && !$past(wr_i) && !$past(wr_i, 2)
		|-> unread_count_o <= $past(unread_count_o)) else $error("count rose without push");
	a_oe_idle: assert property (csb_n_i [*8] |-> !sdo_oe_o)
		else $error("output driven while deselected");
endmodule // esf_fifo_chk
bind esf_fifo esf_fifo_chk #(.AW(AW)) u_chk (
	.clk_i(clk_i),
	.reset_i(reset_i),
	.csb_n_i(csb_n_i),
	.wr_i(wr_i),
	.sample_ready_threshold_i(sample_ready_threshold_i),
	.resynchronise_command_i(resynchronise_command_i),
	.buffer_reset_i(buffer_reset_i),
	.sdo_oe_o(sdo_oe_o),
	.sample_ready_flag_o(sample_ready_flag_o),
	.sample_overflow_flag_o(sample_overflow_flag_o),
	.unread_count_o(unread_count_o)
);

// ### test/esf_host.sv
// serial host model reading the sample port
`timescale 1ns/1ps
module esf_host (
	// serial pins
	output logic sclk_o,
	output logic csb_n_o,
	output logic sdi_o,
	input wire sdo_i
);
	logic [23:0] rd_q[$];
	// one frame: command byte, then nw words sampled on rising sclk
	task automatic frame(input logic [7:0] cmd, input int nw);
		logic [23:0] w;
		w = 24'h0;
		// 1 ns offset keeps every pin change off the bench clock edges
		#1 csb_n_o = 1'b0;
		for (int i = 0; i < 8 + 24 * nw; i++) begin
			sdi_o = (i < 8) ? cmd[7 - i] : ~sdi_o; // data phase input is junk
			#62.5 sclk_o = 1'b1;
			w = {w[22:0], sdo_i};
			if (i >= 8 && (i - 8) % 24 == 23) rd_q.push_back(w);
			#62.5 sclk_o = 1'b0;
		end
		// clock stands still between frames
		#250 csb_n_o = 1'b1;
		#499;
	endtask
	initial begin
		sclk_o = 1'b0;
		csb_n_o = 1'b1;
		sdi_o = 1'b0;
	end
endmodule // esf_host

// ### test/tb.sv
// self-checking bench for the ecg sample fifo readout
`timescale 1ns/1ps
module tb;
	logic clk_i = 0, reset_i = 1, wr_i = 0, wr_fast_i = 0, beat_wr_i = 0, buffer_reset_i = 0;
	logic resynchronise_command_i = 0;
	logic [17:0] wr_volt_i = 0;
	logic [2:0] wr_pace_i = 0, imp_tag_i = 0;
	logic [19:0] imp_volt_i = 0;
	logic [13:0] beat_interval_i = 0;
	logic [4:0] sample_ready_threshold_i = 5'h03;
	wire sclk, csb_n, sdi, sdo_o, sdo_oe_o, sample_ready_flag_o, sample_overflow_flag_o;
	wire [5:0] unread_count_o;
	int err_total = 0, samples_checked = 0, seed = 13414;
	logic [23:0] exp_q[$];
	always #5 clk_i = ~clk_i;
	esf_fifo DUT (.clk_i, .reset_i, .sclk_i(sclk), .csb_n_i(csb_n), .sdi_i(sdi), .sdo_o, .sdo_oe_o,
		.wr_i, .wr_volt_i, .wr_fast_i, .wr_pace_i, .imp_volt_i, .imp_tag_i, .beat_wr_i, .beat_interval_i,
		.sample_ready_threshold_i, .resynchronise_command_i, .buffer_reset_i, .sample_ready_flag_o,
		.sample_overflow_flag_o, .unread_count_o);
	// released data line idles high, so undriven bits never look like held data
	esf_host host (.sclk_o(sclk), .csb_n_o(csb_n), .sdi_o(sdi), .sdo_i(sdo_oe_o ? sdo_o : 1'b1));
	// ready flag expectation: threshold code n asks for n+1 unread entries
	function automatic logic ready_exp(input int n, input logic [4:0] th);
		return n >= th + 1;
	endfunction
	task automatic test_done();
		if (err_total == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// back-to-back pushes; the model keeps at most the depth
	task automatic push(input int n);
		logic [17:0] v;
		logic [2:0] p;
		logic f;
		repeat (n) begin
			v = $random(seed);
			f = $random(seed);
			p = v[0] ? 3'h7 : 3'($unsigned($random(seed)) % 6);
			@(posedge clk_i);
			{wr_i, wr_volt_i, wr_fast_i, wr_pace_i} <= {1'b1, v, f, p};
			if (exp_q.size() < 32) exp_q.push_back({v, 2'b00, f, p});
		end
		@(posedge clk_i) wr_i <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
	// read nw words; the last stored word carries the end tag
	task automatic rd(input logic [6:0] a, input int nw);
		logic [23:0] g, e;
		// a single read hands over one word per frame; only a burst runs on
		if (a == 7'h20) host.frame({a, 1'b1}, nw);
		else repeat (nw) host.frame({a, 1'b1}, 1);
		repeat (nw) begin
			g = host.rd_q.pop_front();
			if (exp_q.size() == 0) check("empty_tag", g[5:3], 3'h6);
			else begin
				e = exp_q.pop_front();
				e[4] = (exp_q.size() == 0);
				check("sample_word", g, e);
			end
		end
		check("unread", unread_count_o, exp_q.size());
	endtask
	task automatic clear(input bit rs);
		@(posedge clk_i) {resynchronise_command_i, buffer_reset_i} <= {rs, !rs};
		@(posedge clk_i) {resynchronise_command_i, buffer_reset_i} <= 2'b00;
		repeat (4) @(posedge clk_i);
		exp_q.delete();
		check("clear_count", {unread_count_o, sample_overflow_flag_o}, 0);
		check("clear_flag", sample_ready_flag_o, 0);
	endtask
	initial begin
		repeat (90000) @(posedge clk_i);
		err_total++;
		test_done();
	end
	initial begin
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		push(5);
		check("ready_flag", sample_ready_flag_o, 1);
		rd(7'h21, 2);
		check("ready_flag", sample_ready_flag_o, 0);
		rd(7'h20, 3);
		rd(7'h21, 1);
		@(posedge clk_i) sample_ready_threshold_i <= 5'h1F;
		push(32);
		check("ready_full", sample_ready_flag_o, ready_exp(32, 5'h1F));
		rd(7'h20, 32);
		push(2);
		host.frame({7'h21, 1'b0}, 1);
		check("write_ignored", unread_count_o, 2);
		check("write_quiet", host.rd_q.pop_front(), 24'hFFFFFF);
		host.frame({7'h24, 1'b1}, 1);
		check("unmapped", host.rd_q.pop_back(), 0);
		rd(7'h21, 2);
		push(33);
		check("overflow", sample_overflow_flag_o, 1);
		host.frame({7'h21, 1'b1}, 1);
		check("ovf_tag", host.rd_q.pop_front() >> 3 & 7, 3'h7);
		clear(0);
		@(posedge clk_i) sample_ready_threshold_i <= 5'($random(seed));
		push(4);
		check("ready_rand", sample_ready_flag_o, ready_exp(4, sample_ready_threshold_i));
		clear(1);
		@(posedge clk_i) {imp_volt_i, imp_tag_i, beat_wr_i, beat_interval_i} <= {20'hA5C3E, 3'h5, 1'b1, 14'h1234};
		@(posedge clk_i) {beat_wr_i, beat_interval_i} <= {1'b1, 14'h2A5B};
		@(posedge clk_i) beat_wr_i <= 1'b0;
		host.frame({7'h22, 1'b1}, 1);
		check("impedance_burst", host.rd_q.pop_front(), {20'hA5C3E, 1'b0, 3'h5});
		host.frame({7'h23, 1'b1}, 1);
		check("impedance", host.rd_q.pop_front(), {20'hA5C3E, 1'b0, 3'h5});
		host.frame({7'h25, 1'b1}, 1);
		check("beat", host.rd_q.pop_front(), {14'h2A5B, 10'h000});
		test_done();
	end
endmodule // tb
